// ---- tpmc_consts.vh ----
// Functional notes
// - After reset clock source select is 0:0, counter idle; 0:1 selects bus clock.
// - Clock source select 1:1 drives prescaler from external clock on channel 0 pin.
// - External clock is synchronised by bus clock; at most quarter bus rate.
// - Prescaler divides by 1, 2, 4, 8, 16, 32, 64 or 128.
// - Up mode counts zero to terminal count, then wraps to zero.
// - Modulus of zero or all ones gives free running 16-bit count.
// - Center mode counts up to modulus, down to zero; ends last one tick.
// - Center-aligned select forces all channels into center-aligned PWM.
// - Up mode sets overflow flag on terminal count to zero step.
// - Up/down mode sets overflow flag on modulus to next lower step.
// - Interrupt request is a level while flag and enable are both one.
// - Reading either counter byte latches both; fresh value after both read.
// - Writing either counter byte resets counter and read coherency.
// - Counting halts in debug and stop mode, runs in wait mode.
// - Timer-owned pin ignores port data and direction settings.
// - After reset module disabled, pins are inputs with pull-ups off.
`ifndef TPMC_CONSTS_VH
`define TPMC_CONSTS_VH
// Byte addresses
`define TPMC_SC_ADDR     6'h00
`define TPMC_CNTH_ADDR   6'h04
`define TPMC_CNTL_ADDR   6'h08
`define TPMC_MODH_ADDR   6'h0c
`define TPMC_MODL_ADDR   6'h10
`define TPMC_IST_ADDR    6'h14
`define TPMC_ICLR_ADDR   6'h18
`define TPMC_IEN_ADDR    6'h1c
`define TPMC_PIN_ADDR    6'h20
// Status/control fields
`define TPMC_PS_LSB      0
`define TPMC_CS_LSB      3
`define TPMC_CPWM_BIT    5
`define TPMC_OFIE_BIT    6
`define TPMC_OFF_BIT     7
// Clock source codes
`define TPMC_CS_OFF      2'h0
`define TPMC_CS_BUS      2'h1
`define TPMC_CS_FIX      2'h2
`define TPMC_CS_EXT      2'h3
// Reset values
`define TPMC_SC_RST      8'h00
`define TPMC_MOD_RST     16'h0000
`define TPMC_PIN_RST     2'h0
`endif

// ---- tpmc_counter.v ----
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tpmc_consts.vh"
module tpmc_counter (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [5:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [5:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Clock sources and system modes
   input  wire        fixed_clk_en,
   input  wire        debug_halt,
   input  wire        stop_mode,
   // Channel 0 pin
   input  wire        channel_pin_i,
   output reg         channel_pin_o,
   output reg         channel_pin_oe,
   output reg         channel_pin_pullup,
   output reg         channel_pin_owned,
   // Counter state for channels
   output reg  [15:0] count_value,
   output reg         count_down,
   output reg         center_aligned_all,
   // Interrupt
   output reg         irq
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg  [2:0]  prescale_r;
   reg  [1:0]  clock_source_select_r;
   reg         center_aligned_select_r;
   reg         overflow_interrupt_enable_r;
   reg         overflow_flag_r;
   reg  [15:0] count_r;
   reg         down_r;
   reg  [15:0] modulus_r;
   reg  [7:0]  mod_hold_r;
   reg         mod_half_r;
   reg  [15:0] snap_r;
   reg  [1:0]  snap_read_r;
   reg         pullup_en_r;
   reg         ext_meta_r;
   reg         ext_sync_r;
   reg         ext_prev_r;
   reg  [6:0]  div_r;
   reg  [1:0]  ist_r;
   reg  [1:0]  ien_r;
   reg  [5:0]  aw_addr_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   reg         aw_have_r;
   reg         w_have_r;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function [6:0] ps_mask;
      input [2:0] ps;
      begin
         ps_mask = (7'h01 << ps) - 7'h01;
      end
   endfunction

   function is_cnt;
      input [5:0] a;
      begin
         is_cnt = (a == `TPMC_CNTH_ADDR) || (a == `TPMC_CNTL_ADDR);
      end
   endfunction

   // ----------------------------------------------------------------
   // Clock source and prescaler
   // ----------------------------------------------------------------
   wire ext_rise = ext_sync_r & ~ext_prev_r;
   reg  src_tick;
   always @* begin
      case (clock_source_select_r)
         `TPMC_CS_OFF: src_tick = 1'b0;
         `TPMC_CS_BUS: src_tick = 1'b1;
         `TPMC_CS_FIX: src_tick = fixed_clk_en;
         `TPMC_CS_EXT: src_tick = ext_rise;
         default:      src_tick = 1'b0;
      endcase
   end
   wire run = src_tick & ~debug_halt & ~stop_mode;
   wire tick = run && ((div_r & ps_mask(prescale_r)) == ps_mask(prescale_r));

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   wire        aw_ok = aw_have_r;
   wire        w_ok  = w_have_r;
   wire [5:0]  wa    = aw_addr_r;
   wire [31:0] wd    = w_data_r;
   wire        wb0   = w_strb_r[0];
   wire        wdo   = aw_ok & w_ok & ~s_axi_bvalid;
   wire        wr    = wdo & wb0;
   wire        wr_sc   = wr && wa == `TPMC_SC_ADDR;
   wire        wr_cnt  = wdo && is_cnt(wa);
   wire        wr_modh = wr && wa == `TPMC_MODH_ADDR;
   wire        wr_modl = wr && wa == `TPMC_MODL_ADDR;
   wire        wr_iclr = wr && wa == `TPMC_ICLR_ADDR;
   wire        wr_ien  = wr && wa == `TPMC_IEN_ADDR;
   wire        wr_pin  = wr && wa == `TPMC_PIN_ADDR;
   wire        wa_ok   = (wa <= `TPMC_PIN_ADDR) && (wa[1:0] == 2'h0);
   wire        rd      = s_axi_arvalid & s_axi_arready;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // zero or all ones run free
   wire        free  = (modulus_r == 16'h0000) || (modulus_r == 16'hffff);
   wire [15:0] term  = free ? 16'hffff : modulus_r;
   wire        at_tc = (count_r == term);
   reg  [15:0] count_nxt;
   reg         down_nxt;
   reg         ovf;
   always @* begin
      count_nxt = count_r;
      down_nxt  = down_r;
      ovf       = 1'b0;
      if (tick) begin
         if (!center_aligned_select_r) begin
            down_nxt = 1'b0;
            if (at_tc) begin
               count_nxt = 16'h0000;
               ovf = 1'b1;
            end else begin
               count_nxt = count_r + 16'h0001;
            end
         end else if (!down_r) begin
            if (at_tc) begin
               down_nxt  = 1'b1;
               count_nxt = count_r - 16'h0001;
               ovf = 1'b1;
            end else begin
               count_nxt = count_r + 16'h0001;
            end
         end else if (count_r == 16'h0000 || count_r == 16'h0001) begin
            down_nxt  = (count_r != 16'h0000) ? 1'b1 : 1'b0;
            count_nxt = (count_r == 16'h0000) ? 16'h0001 : 16'h0000;
         end else begin
            count_nxt = count_r - 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequential state
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         clock_source_select_r       <= `TPMC_CS_OFF;
         prescale_r                  <= 3'h0;
         center_aligned_select_r     <= 1'b0;
         overflow_interrupt_enable_r <= 1'b0;
         overflow_flag_r             <= 1'b0;
         count_r                     <= 16'h0000;
         down_r                      <= 1'b0;
         modulus_r                   <= `TPMC_MOD_RST;
         mod_hold_r                  <= 8'h00;
         mod_half_r                  <= 1'b0;
         snap_r                      <= 16'h0000;
         snap_read_r                 <= 2'h0;
         pullup_en_r                 <= 1'b0;
         ext_meta_r                  <= 1'b0;
         ext_sync_r                  <= 1'b0;
         ext_prev_r                  <= 1'b0;
         div_r                       <= 7'h00;
         ist_r                       <= 2'h0;
         ien_r                       <= 2'h0;
         aw_have_r                   <= 1'b0;
         w_have_r                    <= 1'b0;
         aw_addr_r                   <= 6'h00;
         w_data_r                    <= 32'h0000_0000;
         w_strb_r                    <= 4'h0;
      end else begin
         ext_meta_r <= channel_pin_i;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
         if (run) begin
            div_r <= div_r + 7'h01;
         end
         if (wr_cnt) begin
            count_r <= 16'h0000;
            down_r  <= 1'b0;
            div_r   <= 7'h00;
         end else begin
            count_r <= count_nxt;
            down_r  <= down_nxt;
         end
         // Write address/data held until both present
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wdo) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
         end
         if (wr_sc) begin
            prescale_r                  <= wd[`TPMC_PS_LSB +: 3];
            clock_source_select_r       <= wd[`TPMC_CS_LSB +: 2];
            center_aligned_select_r     <= wd[`TPMC_CPWM_BIT];
            overflow_interrupt_enable_r <= wd[`TPMC_OFIE_BIT];
            mod_half_r                  <= 1'b0;
         end
         if (wr_modh) begin
            mod_hold_r <= wd[7:0];
            mod_half_r <= 1'b1;
         end
         if (wr_modl) begin
            modulus_r  <= {mod_half_r ? mod_hold_r : modulus_r[15:8],
                           wd[7:0]};
            mod_half_r <= 1'b0;
         end
         if (wr_pin) begin
            pullup_en_r <= wd[0];
         end
         if (wr_ien) begin
            ien_r <= wd[1:0];
         end
         // Flag clear on writing zero to status bit, set wins
         if (wr_sc && !wd[`TPMC_OFF_BIT]) begin
            overflow_flag_r <= ovf;
         end else if (ovf) begin
            overflow_flag_r <= 1'b1;
         end
         if (wr_iclr) begin
            ist_r <= (ist_r & ~wd[1:0]) | {1'b0, ovf};
         end else begin
            ist_r <= ist_r | {1'b0, ovf};
         end
         if (wr_cnt) begin
            snap_read_r <= 2'h0;
         end else if (rd && is_cnt(s_axi_araddr)) begin
            if (snap_read_r == 2'h0) begin
               snap_r <= count_r;
            end
            if ((snap_read_r | {s_axi_araddr == `TPMC_CNTH_ADDR,
                                s_axi_araddr == `TPMC_CNTL_ADDR}) == 2'h3) begin
               snap_read_r <= 2'h0;
            end else begin
               snap_read_r <= snap_read_r |
                  {s_axi_araddr == `TPMC_CNTH_ADDR,
                   s_axi_araddr == `TPMC_CNTL_ADDR};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   wire [15:0] cnt_view = (snap_read_r == 2'h0) ? count_r : snap_r;
   reg  [31:0] rd_word;
   always @* begin
      case (s_axi_araddr)
         `TPMC_SC_ADDR:   rd_word = {24'h0, overflow_flag_r,
                                     overflow_interrupt_enable_r,
                                     center_aligned_select_r,
                                     clock_source_select_r, prescale_r};
         `TPMC_CNTH_ADDR: rd_word = {24'h0, cnt_view[15:8]};
         `TPMC_CNTL_ADDR: rd_word = {24'h0, cnt_view[7:0]};
         `TPMC_MODH_ADDR: rd_word = {24'h0, modulus_r[15:8]};
         `TPMC_MODL_ADDR: rd_word = {24'h0, modulus_r[7:0]};
         `TPMC_IST_ADDR:  rd_word = {30'h0, ist_r};
         `TPMC_IEN_ADDR:  rd_word = {30'h0, ien_r};
         `TPMC_PIN_ADDR:  rd_word = {31'h0, pullup_en_r};
         default:         rd_word = 32'h0000_0000;
      endcase
   end
   wire ra_ok = (s_axi_araddr <= `TPMC_PIN_ADDR) &&
                (s_axi_araddr[1:0] == 2'h0);

   // ----------------------------------------------------------------
   // Bus handshakes and outputs
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready      <= 1'b0;
         s_axi_wready       <= 1'b0;
         s_axi_bvalid       <= 1'b0;
         s_axi_bresp        <= 2'h0;
         s_axi_arready      <= 1'b0;
         s_axi_rvalid       <= 1'b0;
         s_axi_rresp        <= 2'h0;
         s_axi_rdata        <= 32'h0000_0000;
         count_value        <= 16'h0000;
         count_down         <= 1'b0;
         center_aligned_all <= 1'b0;
         irq                <= 1'b0;
         channel_pin_o      <= 1'b0;
         channel_pin_oe     <= 1'b0;
         channel_pin_pullup <= 1'b0;
         channel_pin_owned  <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_ok & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready  <= ~w_ok & ~s_axi_wready & ~s_axi_bvalid;
         if (wdo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wa_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= ra_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         count_value        <= wr_cnt ? 16'h0000 : count_nxt;
         count_down         <= wr_cnt ? 1'b0 : down_nxt;
         center_aligned_all <= center_aligned_select_r;
         irq <= (overflow_flag_r & overflow_interrupt_enable_r) |
                (|(ist_r & ien_r));
         // pin owned as input, port ignored
         channel_pin_owned  <= (clock_source_select_r == `TPMC_CS_EXT);
         channel_pin_oe     <= 1'b0;
         channel_pin_o      <= 1'b0;
         channel_pin_pullup <= pullup_en_r &
                               (clock_source_select_r == `TPMC_CS_EXT);
      end
   end

endmodule

// ---- tpmc_counter_checker.sv ----
`timescale 1ns/1ps
// ---------------------------------------------
// Port checks on the main counter
// ---------------------------------------------
module tpmc_counter_checker (
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Bus and modes
   input wire        s_axi_bvalid,
   input wire        debug_halt,
   input wire        stop_mode,
   // Pin
   input wire        channel_pin_oe,
   input wire        channel_pin_pullup,
   input wire        channel_pin_owned,
   // Counter and interrupt
   input wire [15:0] count_value,
   input wire        count_down,
   input wire        center_aligned_all,
   input wire        irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_reset_quiet: assert property (
      disable iff (1'b0) !aresetn |=> !irq && count_value == 16'h0000
      && !channel_pin_pullup) else $error("Outputs not cleared by reset");
   a_pin_undriven: assert property (
      !channel_pin_oe) else $error("Pin driven");
   a_pullup_owned: assert property (
      channel_pin_pullup |-> channel_pin_owned) else $error("Pull-up on");
   a_up_step: assert property (
      !center_aligned_all && !$past(center_aligned_all)
      && $changed(count_value) |-> count_value == $past(count_value)
      + 16'h0001 || count_value == 16'h0000) else $error("Bad up step");
   a_center_step: assert property (
      center_aligned_all && $past(center_aligned_all)
      && $changed(count_value) |-> count_value == $past(count_value)
      + 16'h0001 || count_value == $past(count_value) - 16'h0001
      || count_value == 16'h0000) else $error("Bad center step");
   a_down_step: assert property (
      center_aligned_all && $past(center_aligned_all) && $past(count_down)
      && $past(count_value) != 16'h0000 && $changed(count_value)
      |-> count_value == $past(count_value) - 16'h0001
      || count_value == 16'h0000) else $error("Bad down step");
   a_debug_freeze: assert property (
      $past(debug_halt) && $past(debug_halt, 2) |-> $stable(count_value))
      else $error("Count moved in debug");
   a_stop_freeze: assert property (
      $past(stop_mode) && $past(stop_mode, 2) |-> $stable(count_value))
      else $error("Count moved in stop");
   a_irq_release: assert property (
      $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2)) else $error("Request dropped alone");
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "tpmc_consts.vh"
module testbench;
   typedef struct {
      logic [5:0]  a;
      logic [31:0] wd;
      logic [31:0] rd;
      logic [1:0]  rsp;
   } tpmc_row_t;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, fixed_clk_en, debug_halt;
   logic        stop_mode, channel_pin_i;
   logic [5:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  rr;
   logic [15:0] v, v0;
   logic [7:0]  lo;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, channel_pin_o, channel_pin_oe, irq;
   wire         channel_pin_pullup, channel_pin_owned, count_down;
   wire         center_aligned_all;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [15:0] count_value;
   int          mismatches = 0, checks = 0, cycles = 0, n;
   logic [15:0] seqs [2][6] = '{'{1, 2, 3, 0, 1, 2}, '{1, 2, 3, 2, 1, 0}};
   tpmc_row_t   rows [6] = '{'{`TPMC_SC_ADDR, 32'h07, 32'h07, 2'h0},
      '{`TPMC_IEN_ADDR, 32'h01, 32'h01, 2'h0},
      '{`TPMC_PIN_ADDR, 32'h01, 32'h01, 2'h0},
      '{6'h24, 32'hff, 32'h00, 2'h2}, '{6'h02, 32'hff, 32'h00, 2'h2},
      '{`TPMC_IEN_ADDR, 32'h00, 32'h00, 2'h0}};

   tpmc_counter dut_u (.*);

   // ---------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------
   task automatic print_verdict;
      if (mismatches == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic step(output logic [15:0] val, output int cnt);
      cnt = 0;
      v0 = count_value;
      do begin
         @(posedge aclk);
         cnt++;
      end while (count_value === v0);
      val = count_value;
   endtask

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 100000) begin
         mismatches++;
         print_verdict;
      end
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, fixed_clk_en, debug_halt} = 4'h0;
      {stop_mode, channel_pin_i, s_axi_awaddr, s_axi_araddr} = 14'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      chk("reset outputs", 32'h0, {irq, count_value, channel_pin_pullup,
          channel_pin_owned, center_aligned_all});
      rd(`TPMC_SC_ADDR);
      chk("control at reset", 32'h0, rv);
      repeat (20) @(posedge aclk);
      chk("idle count", 32'h0, count_value);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].wd);
         chk("write response", rows[i].rsp, rr);
         rd(rows[i].a);
         chk("read data", rows[i].rd, rv);
         chk("read response", rows[i].rsp, rr);
      end
      for (int m = 0; m < 2; m++) begin
         wr(`TPMC_SC_ADDR, 32'h0);
         wr(`TPMC_MODH_ADDR, 32'h0);
         wr(`TPMC_MODL_ADDR, 32'h3);
         wr(`TPMC_CNTL_ADDR, 32'h0);
         wr(`TPMC_ICLR_ADDR, 32'h1);
         chk("cleared count", 32'h0, count_value);
         wr(`TPMC_SC_ADDR, m ? 32'h28 : 32'h08);
         for (int k = 0; k < 6; k++) begin
            step(v, n);
            chk("count step", seqs[m][k], v);
            if (k > 0) chk("step length", 32'h1, n);
         end
         chk("center select", m, center_aligned_all);
         rd(`TPMC_IST_ADDR);
         chk("overflow status", 32'h1, rv);
         rd(`TPMC_SC_ADDR);
         chk("overflow flag", 32'h1, rv[7]);
      end
      for (int p = 0; p < 8; p++) begin
         wr(`TPMC_SC_ADDR, 32'h08 | p);
         step(v, n);
         step(v, n);
         chk("prescale period", 32'h1 << p, n);
      end
      wr(`TPMC_SC_ADDR, 32'h0);
      wr(`TPMC_MODL_ADDR, 32'h0);
      wr(`TPMC_CNTL_ADDR, 32'h0);
      wr(`TPMC_ICLR_ADDR, 32'h1);
      wr(`TPMC_SC_ADDR, 32'h08);
      while (count_value !== 16'hffff) @(posedge aclk);
      step(v, n);
      chk("full wrap", 32'h0, v);
      rd(`TPMC_IST_ADDR);
      chk("wrap status", 32'h1, rv);
      chk("polled only", 32'h0, irq);
      wr(`TPMC_SC_ADDR, 32'hc8);
      repeat (2) @(posedge aclk);
      chk("request on", 32'h1, irq);
      wr(`TPMC_SC_ADDR, 32'h48);
      repeat (2) @(posedge aclk);
      chk("request off", 32'h0, irq);
      wr(`TPMC_IEN_ADDR, 32'h1);
      repeat (2) @(posedge aclk);
      chk("status request", 32'h1, irq);
      wr(`TPMC_ICLR_ADDR, 32'h1);
      repeat (2) @(posedge aclk);
      chk("status cleared", 32'h0, irq);
      wr(`TPMC_IEN_ADDR, 32'h0);
      wr(`TPMC_CNTL_ADDR, 32'h0);
      repeat (300) @(posedge aclk);
      rd(`TPMC_CNTL_ADDR);
      lo = rv[7:0];
      repeat (50) @(posedge aclk);
      rd(`TPMC_CNTL_ADDR);
      chk("held low byte", lo, rv);
      rd(`TPMC_CNTH_ADDR);
      chk("snapshot", 32'h1, {rv[7:0], lo} > 16'd300
          && {rv[7:0], lo} < count_value);
      rd(`TPMC_CNTL_ADDR);
      chk("fresh low byte", 32'h1, rv[7:0] !== lo);
      wr(`TPMC_CNTH_ADDR, 32'h5a);
      chk("counter reset", 32'h1, count_value < 16'd16);
      rd(`TPMC_CNTL_ADDR);
      chk("coherency reset", 32'h1, rv < 32'd16);
      for (int k = 0; k < 2; k++) begin
         if (k == 1) stop_mode <= 1'b1;
         else debug_halt <= 1'b1;
         repeat (4) @(posedge aclk);
         v = count_value;
         repeat (20) @(posedge aclk);
         chk("halted count", v, count_value);
         debug_halt <= 1'b0;
         stop_mode <= 1'b0;
         repeat (4) @(posedge aclk);
         chk("resumed count", 32'h1, count_value !== v);
      end
      wr(`TPMC_SC_ADDR, 32'h18);
      repeat (2) @(posedge aclk);
      chk("pin taken", 32'hc, {channel_pin_owned, channel_pin_pullup,
          channel_pin_oe, channel_pin_o});
      v = count_value;
      // channel 0 kept off the clock pin
      // external clock at one eighth of bus rate
      for (int k = 0; k < 5; k++) begin
         channel_pin_i <= 1'b1;
         repeat (4) @(posedge aclk);
         channel_pin_i <= 1'b0;
         repeat (4) @(posedge aclk);
      end
      repeat (6) @(posedge aclk);
      chk("external count", v + 16'd5, count_value);
      wr(`TPMC_SC_ADDR, 32'h10);
      v = count_value;
      for (int k = 0; k < 6; k++) begin
         fixed_clk_en <= 1'b1;
         @(posedge aclk);
         fixed_clk_en <= 1'b0;
         repeat (2) @(posedge aclk);
      end
      repeat (4) @(posedge aclk);
      chk("fixed count", v + 16'd6, count_value);
      chk("pin released", 32'h0, channel_pin_owned);
      print_verdict;
   end
endmodule

bind tpmc_counter tpmc_counter_checker chk_u (.*);
